// file: inc/rtsb_consts.svh
// Constants for the time-stamp record buffer: serial codes, register
// offsets, bit positions, reset values and timing figures.
// Assumes it is included by bare name from the package and the design.
`ifndef RTSB_CONSTS_SVH
`define RTSB_CONSTS_SVH

// Serial command nibble: bit 3 set means read, low bits give the bank
`define RTSB_MODE_RD_BIT 3
`define RTSB_BANK_FLAGS 3'h1
`define RTSB_BANK_STAMP 3'h2
`define RTSB_BANK_CTRL 3'h3
`define RTSB_BANK_RAM_LO 3'h4

// Bank 1 offsets and bits
`define RTSB_ADR_FLAG 4'hE
`define RTSB_ADR_CONTROL 4'hF
`define RTSB_BIT_EVENT_FLAG 3
`define RTSB_BIT_OSC_STOP 0
`define RTSB_BIT_EVENT_IRQ_EN 4

// Bank 2 offsets and bits
`define RTSB_ADR_STATUS_STAMP 4'h9
`define RTSB_ADR_OVERWRITE 4'hB
`define RTSB_ADR_CMD_CTRL 4'hE
`define RTSB_ADR_CMD_TRIG 4'hF
`define RTSB_BIT_OVERWRITE 1
`define RTSB_BIT_CMD_ENABLE 0
`define RTSB_BIT_STAMP_SUPPLY_DETECT_STATUS 3
`define RTSB_BIT_STAMP_XST 1
`define RTSB_STAMP_BYTES 10

// Bank 3 offsets and bits
`define RTSB_ADR_CTRL_ONE 4'h4
`define RTSB_ADR_CTRL_TWO 4'h5
`define RTSB_ADR_BUF_STATE 4'h6
`define RTSB_BIT_FULL_IRQ_SEL 2
`define RTSB_BIT_INDEX_RESET 1
`define RTSB_BIT_RAM_SELECT 0
`define RTSB_BIT_VOLT_EN 2
`define RTSB_BIT_OSC_EN 0

// Record buffer
`define RTSB_SLOT_RESET 3'h7
`define RTSB_SLOT_LAST 3'h7
`define RTSB_REC_BYTES 8

// Oscillator stop qualification time
`define RTSB_OSC_STOP_MS 10
`define RTSB_CLK_KHZ 100000

`endif

// file: inc/rtsb_pkg.sv
// Types shared by the time-stamp record buffer.
// Assumes rtsb_consts.svh is on the include path.
package rtsb_pkg;
`include "rtsb_consts.svh"

   // Calendar time offered by the clock counters, one byte per field
   typedef struct packed {
      logic [7:0] year;
      logic [7:0] month;
      logic [7:0] day;
      logic [7:0] week;
      logic [7:0] hour;
      logic [7:0] min;
      logic [7:0] sec;
      logic [7:0] sub128;
      logic [7:0] sub1024;
   } rtsb_time_t;

   // Record buffer state word
   typedef struct packed {
      logic full;
      logic empty;
      logic [2:0] slot;
   } rtsb_buf_t;

   // Serial receiver phases
   typedef enum logic [1:0] {
      SPI_IDLE,
      SPI_CMD,
      SPI_DATA
   } rtsb_spi_state_t;
endpackage

// file: rtl/rtsb_stamp_top.sv
// Time-stamp capture and eight-record buffer with its serial register port.
// Assumes cal_time_i comes from clock counters on sys_clk; serial pins and
// the supply / oscillator levels are asynchronous and are synchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "rtsb_consts.svh"
module rtsb_stamp_top
   import rtsb_pkg::*;
#(
   parameter int unsigned OSC_STOP_CYCLES = `RTSB_OSC_STOP_MS * `RTSB_CLK_KHZ,
   parameter int CNT_W = 21
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   // Serial register port
   input wire logic spi_ce_i,
   input wire logic spi_sclk_i,
   input wire logic spi_mosi_i,
   output logic spi_miso_o,
   output logic spi_miso_oe_o,
   // Monitored levels and calendar time
   input wire logic supply_detect_i,
   input wire logic osc_running_i,
   input wire rtsb_time_t cal_time_i,
   // Open-drain interrupt, driven low while int_oe_o is high
   output logic int_n_o,
   output logic int_oe_o
);
   localparam logic [CNT_W-1:0] STOP_LAST = CNT_W'(OSC_STOP_CYCLES - 1);

   // Bank and direction decode of the command nibble
   function automatic logic [2:0] bank_of(input logic [3:0] mode);
      return mode[2:0];
   endfunction

   function automatic logic is_read(input logic [3:0] mode);
      return mode[`RTSB_MODE_RD_BIT];
   endfunction

   // Reset release through two flops
   logic [1:0] rst_pipe_reg;
   logic rst_n;
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         rst_pipe_reg <= 2'h0;
      else
         rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
   end
   assign rst_n = rst_pipe_reg[1];

   // Asynchronous inputs; the link clock is sampled like any other level
   logic [4:0] sync_q;
   rtsb_sync #(.WIDTH(5)) u_sync (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n),
      .d_i({spi_ce_i, spi_sclk_i, spi_mosi_i, supply_detect_i, ~osc_running_i}),
      .q_o(sync_q)
   );
   logic ce_q, sclk_q, mosi_q, supply_detect_status_q, osc_q, osc_stopped_q;
   assign {ce_q, sclk_q, mosi_q, supply_detect_status_q, osc_stopped_q} = sync_q;
   // Crosses inverted so the cleared synchroniser reads as running: no false resume edge
   assign osc_q = ~osc_stopped_q;

   // Edge history, kept behind the synchroniser output
   logic sclk_prev_reg, supply_detect_status_prev_reg, osc_prev_reg;
   logic sclk_rise, supply_detect_status_rise, osc_rise;
   always_ff @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sclk_prev_reg <= 1'b0;
         supply_detect_status_prev_reg <= 1'b0;
         osc_prev_reg <= 1'b1;
      end
      else
      begin
         sclk_prev_reg <= sclk_q;
         supply_detect_status_prev_reg <= supply_detect_status_q;
         osc_prev_reg <= osc_q;
      end
   end
   assign sclk_rise = sclk_q & ~sclk_prev_reg;
   assign supply_detect_status_rise = supply_detect_status_q & ~supply_detect_status_prev_reg;
   assign osc_rise = osc_q & ~osc_prev_reg;

   // Serial receiver state
   rtsb_spi_state_t spi_state_reg, spi_state_next;
   logic [2:0] bit_cnt_reg, bit_cnt_next;
   logic [7:0] rx_reg, rx_next;
   logic [7:0] tx_reg, tx_next;
   logic [3:0] mode_reg, mode_next;
   logic [3:0] addr_reg, addr_next;
   logic miso_oe_reg, miso_oe_next;
   logic [7:0] rx_shift;
   logic [3:0] rd_addr;
   logic [2:0] rd_bank;
   logic rd_load;
   logic wr_en;
   logic [7:0] rd_data;

   // Host sends a 4-bit mode and 4-bit address, then bytes; address wraps F to 0
   always_comb
   begin
      spi_state_next = spi_state_reg;
      bit_cnt_next = bit_cnt_reg;
      rx_next = rx_reg;
      tx_next = tx_reg;
      mode_next = mode_reg;
      addr_next = addr_reg;
      miso_oe_next = miso_oe_reg;
      rx_shift = {rx_reg[6:0], mosi_q};
      rd_addr = addr_reg + 4'h1;
      rd_bank = bank_of(mode_reg);
      rd_load = 1'b0;
      wr_en = 1'b0;
      case (spi_state_reg)
         SPI_IDLE:
         begin
            bit_cnt_next = 3'h0;
            miso_oe_next = 1'b0;
            if (ce_q)
               spi_state_next = SPI_CMD;
         end
         SPI_CMD:
         begin
            if (sclk_rise)
            begin
               rx_next = rx_shift;
               bit_cnt_next = bit_cnt_reg + 3'h1;
               if (bit_cnt_reg == 3'h7)
               begin
                  mode_next = rx_shift[7:4];
                  addr_next = rx_shift[3:0];
                  spi_state_next = SPI_DATA;
                  rd_addr = rx_shift[3:0];
                  rd_bank = bank_of(rx_shift[7:4]);
                  rd_load = is_read(rx_shift[7:4]);
                  miso_oe_next = is_read(rx_shift[7:4]);
               end
            end
         end
         SPI_DATA:
         begin
            if (sclk_rise)
            begin
               rx_next = rx_shift;
               tx_next = {tx_reg[6:0], 1'b0};
               bit_cnt_next = bit_cnt_reg + 3'h1;
               if (bit_cnt_reg == 3'h7)
               begin
                  addr_next = addr_reg + 4'h1;
                  rd_load = is_read(mode_reg);
                  wr_en = ~is_read(mode_reg);
               end
            end
         end
         default:
            spi_state_next = SPI_IDLE;
      endcase
      if (rd_load)
         tx_next = rd_data;
      // A partial byte at the end of a frame is dropped, not written
      if (!ce_q)
         spi_state_next = SPI_IDLE;
   end

   always_ff @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         spi_state_reg <= SPI_IDLE;
         bit_cnt_reg <= 3'h0;
         rx_reg <= 8'h00;
         tx_reg <= 8'h00;
         mode_reg <= 4'h0;
         addr_reg <= 4'h0;
         miso_oe_reg <= 1'b0;
      end
      else
      begin
         spi_state_reg <= spi_state_next;
         bit_cnt_reg <= bit_cnt_next;
         rx_reg <= rx_next;
         tx_reg <= tx_next;
         mode_reg <= mode_next;
         addr_reg <= addr_next;
         miso_oe_reg <= miso_oe_next && ce_q;
      end
   end
   assign spi_miso_o = tx_reg[7];
   assign spi_miso_oe_o = miso_oe_reg;

   // Control and status state
   logic event_flag_reg, event_flag_next;
   logic osc_stop_status_reg, osc_stop_status_next;
   logic event_irq_enable_reg, event_irq_enable_next;
   logic overwrite_allow_reg, overwrite_allow_next;
   logic cmd_enable_reg, cmd_enable_next;
   logic full_irq_select_reg, full_irq_select_next;
   logic record_ram_select_reg, record_ram_select_next;
   logic volt_detect_stamp_enable_reg, volt_detect_stamp_enable_next;
   logic osc_stop_stamp_enable_reg, osc_stop_stamp_enable_next;
   logic irq_pend_reg, irq_pend_next;
   logic stop_long_reg, stop_long_next;
   logic [CNT_W-1:0] stop_cnt_reg, stop_cnt_next;
   rtsb_buf_t buf_reg, buf_next;
   logic [`RTSB_STAMP_BYTES-1:0][7:0] stamp_reg, stamp_next;
   logic [7:0] ram_mem [0:63];
   logic [7:0] wr_byte;
   logic [2:0] wr_bank;
   logic evt_supply_detect_status, evt_xst, evt_cmd, hw_evt, any_evt;
   logic index_clr, rec_ok;
   logic [2:0] slot_new;
   logic [`RTSB_REC_BYTES-1:0][7:0] rec_bytes;

   assign wr_byte = rx_shift;
   assign wr_bank = bank_of(mode_reg);
   assign slot_new = buf_reg.slot + 3'h1;
   assign index_clr = wr_en && wr_bank == `RTSB_BANK_CTRL && addr_reg == `RTSB_ADR_CTRL_ONE
      && wr_byte[`RTSB_BIT_INDEX_RESET];

   // Event sources
   assign evt_supply_detect_status = supply_detect_status_rise & volt_detect_stamp_enable_reg;
   assign evt_xst = osc_rise & stop_long_reg & osc_stop_stamp_enable_reg;
   assign evt_cmd = rd_load && rd_bank == `RTSB_BANK_STAMP && rd_addr == `RTSB_ADR_CMD_TRIG
      && cmd_enable_reg;
   assign hw_evt = evt_supply_detect_status | evt_xst;
   assign any_evt = hw_evt | evt_cmd;
   // No room and no overwrite leaves the record area untouched
   assign rec_ok = any_evt & record_ram_select_reg & ~index_clr
      & ~(buf_reg.full & ~overwrite_allow_reg);

   // Record layout drops 1/1024 second and weekday, keeps status last
   assign rec_bytes = {stamp_next[`RTSB_ADR_STATUS_STAMP], cal_time_i.year,
      cal_time_i.month, cal_time_i.day, cal_time_i.hour, cal_time_i.min,
      cal_time_i.sec, cal_time_i.sub128};

   // Register writes, stamping and buffer bookkeeping
   always_comb
   begin
      event_flag_next = event_flag_reg;
      osc_stop_status_next = osc_stop_status_reg;
      event_irq_enable_next = event_irq_enable_reg;
      overwrite_allow_next = overwrite_allow_reg;
      cmd_enable_next = cmd_enable_reg;
      full_irq_select_next = full_irq_select_reg;
      record_ram_select_next = record_ram_select_reg;
      volt_detect_stamp_enable_next = volt_detect_stamp_enable_reg;
      osc_stop_stamp_enable_next = osc_stop_stamp_enable_reg;
      irq_pend_next = irq_pend_reg;
      stop_long_next = stop_long_reg;
      stop_cnt_next = stop_cnt_reg;
      buf_next = buf_reg;
      stamp_next = stamp_reg;
      // Stop time is counted on sys_clk, which keeps running while the crystal is idle
      if (osc_q)
         stop_cnt_next = '0;
      else if (stop_cnt_reg != STOP_LAST)
         stop_cnt_next = stop_cnt_reg + CNT_W'(1);
      if (!osc_q && stop_cnt_reg == STOP_LAST)
         stop_long_next = 1'b1;
      if (osc_rise)
         stop_long_next = 1'b0;
      if (wr_en)
      begin
         if (wr_bank == `RTSB_BANK_FLAGS && addr_reg == `RTSB_ADR_FLAG)
         begin
            // Writing 1 is ignored, writing 0 clears
            if (!wr_byte[`RTSB_BIT_EVENT_FLAG])
            begin
               event_flag_next = 1'b0;
               irq_pend_next = 1'b0;
            end
            if (!wr_byte[`RTSB_BIT_OSC_STOP])
               osc_stop_status_next = 1'b0;
         end
         if (wr_bank == `RTSB_BANK_FLAGS && addr_reg == `RTSB_ADR_CONTROL)
            event_irq_enable_next = wr_byte[`RTSB_BIT_EVENT_IRQ_EN];
         if (wr_bank == `RTSB_BANK_STAMP && addr_reg == `RTSB_ADR_OVERWRITE)
            overwrite_allow_next = wr_byte[`RTSB_BIT_OVERWRITE];
         if (wr_bank == `RTSB_BANK_STAMP && addr_reg == `RTSB_ADR_CMD_CTRL)
            cmd_enable_next = wr_byte[`RTSB_BIT_CMD_ENABLE];
         if (wr_bank == `RTSB_BANK_CTRL && addr_reg == `RTSB_ADR_CTRL_ONE)
         begin
            full_irq_select_next = wr_byte[`RTSB_BIT_FULL_IRQ_SEL];
            record_ram_select_next = wr_byte[`RTSB_BIT_RAM_SELECT];
         end
         if (wr_bank == `RTSB_BANK_CTRL && addr_reg == `RTSB_ADR_CTRL_TWO)
         begin
            volt_detect_stamp_enable_next = wr_byte[`RTSB_BIT_VOLT_EN];
            osc_stop_stamp_enable_next = wr_byte[`RTSB_BIT_OSC_EN];
         end
      end
      // Set wins over a clear in the same cycle
      if (!osc_q && stop_cnt_reg == STOP_LAST)
         osc_stop_status_next = 1'b1;
      if (index_clr)
         buf_next = '{full: 1'b0, empty: 1'b1, slot: `RTSB_SLOT_RESET};
      if (any_evt)
      begin
         stamp_next = {4'h0, supply_detect_status_q, 1'b0, osc_stop_status_next, 1'b0, cal_time_i};
         if (hw_evt)
            event_flag_next = 1'b1;
      end
      if (rec_ok)
      begin
         buf_next.slot = slot_new;
         buf_next.empty = 1'b0;
         if (slot_new == `RTSB_SLOT_LAST)
            buf_next.full = 1'b1;
      end
      // Command stamps take no part in the interrupt
      if (hw_evt && (!full_irq_select_reg || (rec_ok && slot_new == `RTSB_SLOT_LAST)))
         irq_pend_next = 1'b1;
   end

   always_ff @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         event_flag_reg <= 1'b0;
         osc_stop_status_reg <= 1'b0;
         event_irq_enable_reg <= 1'b0;
         overwrite_allow_reg <= 1'b0;
         cmd_enable_reg <= 1'b0;
         full_irq_select_reg <= 1'b0;
         record_ram_select_reg <= 1'b0;
         volt_detect_stamp_enable_reg <= 1'b0;
         osc_stop_stamp_enable_reg <= 1'b0;
         irq_pend_reg <= 1'b0;
         stop_long_reg <= 1'b0;
         stop_cnt_reg <= '0;
         buf_reg <= '{full: 1'b0, empty: 1'b1, slot: `RTSB_SLOT_RESET};
         stamp_reg <= '0;
      end
      else
      begin
         event_flag_reg <= event_flag_next;
         osc_stop_status_reg <= osc_stop_status_next;
         event_irq_enable_reg <= event_irq_enable_next;
         overwrite_allow_reg <= overwrite_allow_next;
         cmd_enable_reg <= cmd_enable_next;
         full_irq_select_reg <= full_irq_select_next;
         record_ram_select_reg <= record_ram_select_next;
         volt_detect_stamp_enable_reg <= volt_detect_stamp_enable_next;
         osc_stop_stamp_enable_reg <= osc_stop_stamp_enable_next;
         irq_pend_reg <= irq_pend_next;
         stop_long_reg <= stop_long_next;
         stop_cnt_reg <= stop_cnt_next;
         buf_reg <= buf_next;
         stamp_reg <= stamp_next;
      end
   end

   // Banks 4 to 7: host bytes, or whole records; a record wins a same-cycle write
   always_ff @(posedge sys_clk_i)
   begin
      if (wr_en && wr_bank >= `RTSB_BANK_RAM_LO)
         ram_mem[{wr_bank[1:0], addr_reg}] <= wr_byte;
      if (rec_ok)
         for (int i = 0; i < `RTSB_REC_BYTES; i++)
            ram_mem[{slot_new, i[2:0]}] <= rec_bytes[i];
   end

   // Read data for the byte about to be shifted out
   always_comb
   begin
      rd_data = 8'h00;
      case (rd_bank)
         `RTSB_BANK_FLAGS:
         begin
            if (rd_addr == `RTSB_ADR_FLAG)
               rd_data = {4'h0, event_flag_reg, 2'h0, osc_stop_status_reg};
            if (rd_addr == `RTSB_ADR_CONTROL)
               rd_data = {3'h0, event_irq_enable_reg, 4'h0};
         end
         `RTSB_BANK_STAMP:
         begin
            if (rd_addr <= `RTSB_ADR_STATUS_STAMP)
               rd_data = stamp_reg[rd_addr];
            if (rd_addr == `RTSB_ADR_OVERWRITE)
               rd_data = {6'h00, overwrite_allow_reg, 1'b0};
            if (rd_addr == `RTSB_ADR_CMD_CTRL)
               rd_data = {7'h00, cmd_enable_reg};
         end
         `RTSB_BANK_CTRL:
         begin
            if (rd_addr == `RTSB_ADR_CTRL_ONE)
               rd_data = {5'h00, full_irq_select_reg, 1'b0, record_ram_select_reg};
            if (rd_addr == `RTSB_ADR_CTRL_TWO)
               rd_data = {5'h00, volt_detect_stamp_enable_reg, 1'b0,
                  osc_stop_stamp_enable_reg};
            if (rd_addr == `RTSB_ADR_BUF_STATE)
               rd_data = {3'h0, buf_reg};
         end
         3'h4, 3'h5, 3'h6, 3'h7:
            rd_data = ram_mem[{rd_bank[1:0], rd_addr}];
         default:
            rd_data = 8'h00;
      endcase
   end

   // Open-drain interrupt: pulled low only while enabled and pending
   logic int_oe_reg;
   always_ff @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
         int_oe_reg <= 1'b0;
      else
         int_oe_reg <= irq_pend_reg & event_irq_enable_reg;
   end
   assign int_oe_o = int_oe_reg;
   assign int_n_o = 1'b0;

   // Checks on the design's own behaviour
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n);

   sequence s_resume_after_stop;
      osc_rise ##0 stop_long_reg;
   endsequence

   sequence s_event_taken;
      hw_evt ##1 event_flag_reg;
   endsequence

   a_stop_qualify: assert property ($rose(osc_stop_status_reg) |->
      $past(stop_cnt_reg) == STOP_LAST)
      else $error("stop status set before the stop time");
   a_stamp_on_resume: assert property (s_resume_after_stop ##0 osc_stop_stamp_enable_reg
      |=> event_flag_reg)
      else $error("oscillator stamp not at resume");
   a_volt_gate: assert property (supply_detect_status_rise && !volt_detect_stamp_enable_reg && !evt_xst
      && !evt_cmd |=> $stable(stamp_reg))
      else $error("supply stamp taken while disabled");
   a_osc_gate: assert property (osc_rise && stop_long_reg && !osc_stop_stamp_enable_reg
      && !evt_supply_detect_status && !evt_cmd |=> $stable(stamp_reg))
      else $error("oscillator stamp taken while disabled");
   a_slot_advance: assert property (rec_ok |=> buf_reg.slot == $past(buf_reg.slot) + 3'h1
      && !buf_reg.empty)
      else $error("slot pointer did not advance by one");
   a_index_reset: assert property (index_clr |=> buf_reg.slot == `RTSB_SLOT_RESET
      && buf_reg.empty && !buf_reg.full)
      else $error("index reset did not initialise the buffer state");
   a_no_overwrite: assert property (any_evt && buf_reg.full && !overwrite_allow_reg
      && !index_clr |=> $stable(buf_reg))
      else $error("full buffer overwritten without overwrite");
   a_cmd_no_irq: assert property (evt_cmd && !hw_evt && !irq_pend_reg |=> !irq_pend_reg)
      else $error("command stamp raised the interrupt");
   a_event_flag: assert property (hw_evt |-> s_event_taken)
      else $error("event flag not set by an event");
   a_irq_gate: assert property (!event_irq_enable_reg |=> !int_oe_o)
      else $error("interrupt driven while disabled");
   a_full_empty: assert property (buf_reg.full |-> !buf_reg.empty)
      else $error("buffer both full and empty");
endmodule
`default_nettype wire

// file: rtl/rtsb_sync.sv
// Two flip-flop synchroniser for a vector of independent levels.
// Assumes each bit is a level that holds for several clock periods.
`timescale 1ns/1ps
`default_nettype none
module rtsb_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // Levels
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] q_reg;

   // First stage feeds only the second stage
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         meta_reg <= '0;
         q_reg <= '0;
      end
      else
      begin
         meta_reg <= d_i;
         q_reg <= meta_reg;
      end
   end

   assign q_o = q_reg;
endmodule
`default_nettype wire

// file: verification/rtsb_host_model.sv
// Host side of the serial register port: one task runs a two-byte frame.
// Assumes clk_i is the design clock; sclk stands still low between frames.
`timescale 1ns/1ps
`default_nettype none
module rtsb_host_model (
   // Clock
   input wire logic clk_i,
   // Serial lines
   input wire logic miso_i,
   output logic ce_o,
   output logic sclk_o,
   output logic mosi_o
);
   // Idle lines at time zero
   initial
   begin
      ce_o = 1'b0;
      sclk_o = 1'b0;
      mosi_o = 1'b1;
   end
   // Command then data, MSB first; read bits taken just before each rise
   task automatic xfer(input logic [15:0] d, output logic [7:0] r);
      r = 8'h00;
      @(posedge clk_i) ce_o <= 1'b1;
      for (int i = 15; i >= 0; i--)
      begin
         repeat (4) @(posedge clk_i);
         sclk_o <= 1'b0;
         mosi_o <= d[i];
         repeat (4) @(posedge clk_i);
         if (i < 8)
            r = {r[6:0], miso_i};
         sclk_o <= 1'b1;
      end
      repeat (4) @(posedge clk_i);
      ce_o <= 1'b0;
      sclk_o <= 1'b0;
      // Released data line flips so a stale bit cannot pass for data
      mosi_o <= ~d[0];
      repeat (6) @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

// file: verification/rtsb_stamp_top_tb.sv
// Self-checking bench for the time-stamp record buffer.
// Assumes the host model runs frames; the bench drives levels and time.
`timescale 1ns/1ps
`default_nettype none
module rtsb_stamp_top_tb
   import rtsb_pkg::*;
();
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic sup = 1'b0;
   logic osc = 1'b1;
   logic ce, sclk, mosi, miso, int_oe, miso_oe, int_n;
   logic [7:0] r;
   rtsb_time_t cal = 72'h24_07_15_03_12_34_56_78_9A;
   int err_total = 0;
   int checks = 0;
   // Short stop qualification keeps the run brief
   rtsb_stamp_top #(.OSC_STOP_CYCLES(50)) rtsb_stamp_top_i (.sys_clk_i(sys_clk),
      .resetn_i(resetn), .spi_ce_i(ce), .spi_sclk_i(sclk), .spi_mosi_i(mosi),
      .spi_miso_o(miso), .spi_miso_oe_o(miso_oe), .supply_detect_i(sup), .osc_running_i(osc),
      .cal_time_i(cal), .int_n_o(int_n), .int_oe_o(int_oe));
   rtsb_host_model rtsb_host_model_i (.clk_i(sys_clk), .miso_i(miso), .ce_o(ce),
      .sclk_o(sclk), .mosi_o(mosi));
   initial
      forever #5 sys_clk = ~sys_clk;
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   // Register access: write mode is the bank, read mode adds 8
   task automatic wr(input logic [2:0] b, input logic [3:0] a, input logic [7:0] d);
      rtsb_host_model_i.xfer({1'b0, b, a, d}, r);
   endtask
   task automatic rd(input logic [2:0] b, input logic [3:0] a, input logic [7:0] e);
      rtsb_host_model_i.xfer({1'b1, b, a, 8'h00}, r);
      check(r, e);
   endtask
   // Supply detect pulse, long enough for the input synchronisers
   task automatic ev();
      @(posedge sys_clk) sup <= 1'b1;
      repeat (20) @(posedge sys_clk);
      sup <= 1'b0;
      repeat (20) @(posedge sys_clk);
   endtask
   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      err_total++;
      end_of_test();
   end
   initial
   begin
      repeat (5) @(posedge sys_clk);
      resetn <= 1'b1;
      repeat (8) @(posedge sys_clk);
      rd(3'h3, 4'h6, 8'h0F);
      check({6'h00, miso_oe, int_n}, 8'h00);
      rd(3'h3, 4'h4, 8'h00);
      wr(3'h3, 4'h5, 8'h04);
      wr(3'h1, 4'hF, 8'h10);
      wr(3'h3, 4'h4, 8'h03);
      ev();
      check({7'h00, int_oe}, 8'h01);
      rd(3'h3, 4'h6, 8'h00);
      rd(3'h1, 4'hE, 8'h08);
      rd(3'h2, 4'h0, 8'h9A);
      rd(3'h2, 4'h9, 8'h08);
      rd(3'h4, 4'h4, 8'h15);
      rd(3'h4, 4'h7, 8'h08);
      wr(3'h1, 4'hE, 8'h00);
      check({7'h00, int_oe}, 8'h00);
      wr(3'h3, 4'h5, 8'h01);
      ev();
      rd(3'h3, 4'h6, 8'h00);
      $display("Stamp test done");
      // A short stop must not qualify; a long one stamps only on resume
      @(posedge sys_clk) osc <= 1'b0;
      repeat (20) @(posedge sys_clk);
      osc <= 1'b1;
      rd(3'h1, 4'hE, 8'h00);
      @(posedge sys_clk) osc <= 1'b0;
      repeat (100) @(posedge sys_clk);
      rd(3'h3, 4'h6, 8'h00);
      rd(3'h1, 4'hE, 8'h01);
      @(posedge sys_clk) osc <= 1'b1;
      repeat (20) @(posedge sys_clk);
      rd(3'h3, 4'h6, 8'h01);
      rd(3'h4, 4'hF, 8'h02);
      $display("Oscillator test done");
      wr(3'h1, 4'hE, 8'h00);
      wr(3'h3, 4'h5, 8'h04);
      wr(3'h3, 4'h4, 8'h05);
      for (int i = 2; i < 8; i++)
      begin
         check({7'h00, int_oe}, 8'h00);
         ev();
      end
      check({7'h00, int_oe}, 8'h01);
      rd(3'h3, 4'h6, 8'h17);
      @(posedge sys_clk) cal.sub128 <= 8'h55;
      ev();
      rd(3'h3, 4'h6, 8'h17);
      rd(3'h4, 4'h0, 8'h78);
      wr(3'h2, 4'hB, 8'h02);
      rd(3'h2, 4'hB, 8'h02);
      ev();
      rd(3'h3, 4'h6, 8'h10);
      rd(3'h4, 4'h0, 8'h55);
      rd(3'h7, 4'hF, 8'h08);
      $display("Full test done");
      wr(3'h1, 4'hE, 8'h00);
      wr(3'h3, 4'h4, 8'h03);
      rd(3'h3, 4'h6, 8'h0F);
      wr(3'h2, 4'hE, 8'h01);
      rd(3'h2, 4'hF, 8'h00);
      rd(3'h3, 4'h6, 8'h00);
      rd(3'h1, 4'hE, 8'h00);
      check({7'h00, int_oe}, 8'h00);
      rd(3'h4, 4'h0, 8'h55);
      $display("Command test done");
      wr(3'h3, 4'h4, 8'h00);
      wr(3'h4, 4'h8, 8'hA5);
      @(posedge sys_clk) cal.sub1024 <= 8'h11;
      ev();
      rd(3'h2, 4'h0, 8'h11);
      rd(3'h3, 4'h6, 8'h00);
      rd(3'h4, 4'h8, 8'hA5);
      wr(3'h3, 4'h4, 8'h01);
      wr(3'h4, 4'h8, 8'h00);
      rd(3'h4, 4'h8, 8'h00);
      $display("User ram test done");
      end_of_test();
   end
endmodule
`default_nettype wire
